/* common/tpfrs_pkg.sv */
// constants shared by the two-port frame relay switch
// assumes a classic wishbone master and two on-chip mac byte streams on one clock
package tpfrs_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [31:0] TPFRS_OFS_MODE = 32'h0000_0000;
    localparam logic [31:0] TPFRS_OFS_COUNT = 32'h0000_0004;
    localparam logic [31:0] TPFRS_MODE_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // relay_mode_control fields
    // ------------------------------------------------------------
    localparam int TPFRS_BIT_CH1_TO_CH0 = 9;
    localparam int TPFRS_BIT_CH0_TO_CH1 = 8;
    localparam int TPFRS_BIT_METHOD = 0;

    // ------------------------------------------------------------
    // relayed frame count fields
    // ------------------------------------------------------------
    localparam int TPFRS_CNT_W = 16;
    localparam int TPFRS_CNT_LO = 0;
    localparam int TPFRS_CNT_HI = 16;

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    localparam int TPFRS_BYTE_W = 8;
    localparam int TPFRS_ENTRY_W = TPFRS_BYTE_W + 1;
    localparam int TPFRS_LAST_BIT = TPFRS_BYTE_W;
    localparam int TPFRS_DEPTH_LOG2 = 11;
    localparam logic [1:0] TPFRS_SKID_DEPTH = 2'h2;
    localparam int TPFRS_FILL_MARGIN = 2;

endpackage : tpfrs_pkg

/* rtl/tpfrs_frame_ram.sv */
// one direction's frame store: simple dual port memory
// assumes one clock; read data appear one edge after the read request
`timescale 1ns/1ps
module tpfrs_frame_ram #(
    parameter int WIDTH = 9,
    parameter int AW = 11
) (
    input wire logic clk_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [WIDTH-1:0] mem_q [2**AW];
    logic [WIDTH-1:0] rd_data_q;

    // no reset on the array so it maps onto block ram
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i)
        begin
            rd_data_q <= mem_q[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_q;

endmodule : tpfrs_frame_ram

/* rtl/tpfrs_relay.sv */
// two-port frame relay: register slave plus one relay path per direction
// assumes both mac channels and the bus run on clk_i; streams are byte wide
// with valid, ready and a last flag on the final byte of a frame
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module tpfrs_relay #(
    parameter int AW = tpfrs_pkg::TPFRS_DEPTH_LOG2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // channel 0 receive side (frames arriving at port 0)
    input wire logic [7:0] ch0_rx_data_i,
    input wire logic ch0_rx_valid_i,
    input wire logic ch0_rx_last_i,
    output logic ch0_rx_ready_o,
    // channel 0 transmit side
    output logic [7:0] ch0_tx_data_o,
    output logic ch0_tx_valid_o,
    output logic ch0_tx_last_o,
    input wire logic ch0_tx_ready_i,
    // channel 1 receive side
    input wire logic [7:0] ch1_rx_data_i,
    input wire logic ch1_rx_valid_i,
    input wire logic ch1_rx_last_i,
    output logic ch1_rx_ready_o,
    // channel 1 transmit side
    output logic [7:0] ch1_tx_data_o,
    output logic ch1_tx_valid_o,
    output logic ch1_tx_last_o,
    input wire logic ch1_tx_ready_i
);

    localparam int EW = tpfrs_pkg::TPFRS_ENTRY_W;
    localparam int CW = tpfrs_pkg::TPFRS_CNT_W;
    localparam int LB = tpfrs_pkg::TPFRS_LAST_BIT;

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    logic [31:0] mode_q;
    logic [31:0] mode_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic ack_q;
    logic ack_d;
    logic [CW-1:0] frames [2];
    logic wr_take;

    // ack one cycle after the request; the write lands on the acked edge
    always_comb
    begin
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        wr_take = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
        mode_d = mode_q;
        if (wr_take && wb_adr_i == tpfrs_pkg::TPFRS_OFS_MODE)
        begin
            if (wb_sel_i[1])
            begin
                mode_d[tpfrs_pkg::TPFRS_BIT_CH1_TO_CH0] = wb_dat_i[tpfrs_pkg::TPFRS_BIT_CH1_TO_CH0];
                mode_d[tpfrs_pkg::TPFRS_BIT_CH0_TO_CH1] = wb_dat_i[tpfrs_pkg::TPFRS_BIT_CH0_TO_CH1];
            end
            if (wb_sel_i[0])
            begin
                mode_d[tpfrs_pkg::TPFRS_BIT_METHOD] = wb_dat_i[tpfrs_pkg::TPFRS_BIT_METHOD];
            end
        end
        rdat_d = 32'h0000_0000; // unmapped reads answer zero
        if (wb_adr_i == tpfrs_pkg::TPFRS_OFS_MODE)
        begin
            rdat_d = mode_q;
        end
        else if (wb_adr_i == tpfrs_pkg::TPFRS_OFS_COUNT)
        begin
            rdat_d[tpfrs_pkg::TPFRS_CNT_LO +: CW] = frames[0];
            rdat_d[tpfrs_pkg::TPFRS_CNT_HI +: CW] = frames[1];
        end
    end

    // register stage for the slave
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= tpfrs_pkg::TPFRS_MODE_RESET; // both directions off: isolated
            rdat_q <= 32'h0000_0000;
            ack_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            rdat_q <= rdat_d;
            ack_q <= ack_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ------------------------------------------------------------
    // direction mapping: path 0 is ch0 -> ch1, path 1 is ch1 -> ch0
    // ------------------------------------------------------------
    logic [7:0] src_data [2];
    logic [1:0] src_valid;
    logic [1:0] src_last;
    logic [1:0] src_ready;
    logic [EW-1:0] dst_head [2];
    logic [1:0] dst_valid;
    logic [1:0] dst_ready;
    logic [1:0] dir_en;
    logic cut_through;

    assign dir_en[0] = mode_q[tpfrs_pkg::TPFRS_BIT_CH0_TO_CH1];
    assign dir_en[1] = mode_q[tpfrs_pkg::TPFRS_BIT_CH1_TO_CH0];
    assign cut_through = mode_q[tpfrs_pkg::TPFRS_BIT_METHOD];
    assign src_data[0] = ch0_rx_data_i;
    assign src_data[1] = ch1_rx_data_i;
    assign src_valid = {ch1_rx_valid_i, ch0_rx_valid_i};
    assign src_last = {ch1_rx_last_i, ch0_rx_last_i};
    assign dst_ready = {ch0_tx_ready_i, ch1_tx_ready_i};
    assign ch0_rx_ready_o = src_ready[0];
    assign ch1_rx_ready_o = src_ready[1];
    assign ch1_tx_data_o = dst_head[0][7:0];
    assign ch1_tx_last_o = dst_head[0][LB];
    assign ch1_tx_valid_o = dst_valid[0];
    assign ch0_tx_data_o = dst_head[1][7:0];
    assign ch0_tx_last_o = dst_head[1][LB];
    assign ch0_tx_valid_o = dst_valid[1];

    // ------------------------------------------------------------
    // relay paths
    // ------------------------------------------------------------
    localparam logic [AW:0] FILL_LIMIT = (AW+1)'((2**AW) - tpfrs_pkg::TPFRS_FILL_MARGIN);

    for (genvar d = 0; d < 2; d++)
    begin : g_path
        logic [AW:0] wr_q;
        logic [AW:0] wr_d;
        logic [AW:0] cmt_q;
        logic [AW:0] cmt_d;
        logic [AW:0] rd_q;
        logic [AW:0] rd_d;
        logic [AW:0] lim;
        logic [AW:0] used;
        logic in_frame_q;
        logic in_frame_d;
        logic fwd_q;
        logic fwd_d;
        logic ct_q;
        logic ct_d;
        logic rdy_q;
        logic rdy_d;
        logic pend_q;
        logic pend_d;
        logic val_q;
        logic val_d;
        logic [1:0] cnt_q;
        logic [1:0] cnt_d;
        logic [1:0] slot;
        logic [EW-1:0] b0_q;
        logic [EW-1:0] b0_d;
        logic [EW-1:0] b1_q;
        logic [EW-1:0] b1_d;
        logic [CW-1:0] frm_q;
        logic [CW-1:0] frm_d;
        logic acc;
        logic wr_en;
        logic rd_en;
        logic pop;
        logic [EW-1:0] ram_rd;

        // writer: enable and method are caught on a frame's first byte so a
        // register write never splits a frame in half
        always_comb
        begin
            acc = src_valid[d] && rdy_q;
            fwd_d = fwd_q;
            ct_d = ct_q;
            in_frame_d = in_frame_q;
            if (acc && !in_frame_q)
            begin
                fwd_d = dir_en[d];
                ct_d = cut_through;
            end
            if (acc)
            begin
                in_frame_d = !src_last[d];
            end
            wr_en = acc && (in_frame_q ? fwd_q : dir_en[d]);
            wr_d = wr_en ? wr_q + 1'b1 : wr_q;
            cmt_d = (wr_en && src_last[d]) ? wr_d : cmt_q;
            // reader may chase the writer only in cut-through
            lim = ct_q ? wr_q : cmt_q;
        end

        // reader and two-entry output buffer; a read is only issued when the
        // buffer has room for it, so a stalled mac loses nothing
        always_comb
        begin
            pop = val_q && dst_ready[d];
            rd_en = (rd_q != lim) && ((cnt_q + {1'b0, pend_q}) < tpfrs_pkg::TPFRS_SKID_DEPTH);
            rd_d = rd_en ? rd_q + 1'b1 : rd_q;
            pend_d = rd_en;
            b0_d = b0_q;
            b1_d = b1_q;
            slot = cnt_q;
            if (pop)
            begin
                b0_d = b1_q;
                slot = cnt_q - 2'h1;
            end
            if (pend_q)
            begin
                if (slot == 2'h0)
                begin
                    b0_d = ram_rd;
                end
                else
                begin
                    b1_d = ram_rd;
                end
            end
            cnt_d = slot + {1'b0, pend_q};
            val_d = cnt_d != 2'h0;
            used = wr_d - rd_d;
            rdy_d = used < FILL_LIMIT;
            frm_d = (pop && b0_q[LB]) ? frm_q + 1'b1 : frm_q;
        end

        // path registers
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                wr_q <= '0;
                cmt_q <= '0;
                rd_q <= '0;
                in_frame_q <= 1'b0;
                fwd_q <= 1'b0;
                ct_q <= 1'b0;
                rdy_q <= 1'b0;
                pend_q <= 1'b0;
                val_q <= 1'b0;
                cnt_q <= 2'h0;
                b0_q <= '0;
                b1_q <= '0;
                frm_q <= '0;
            end
            else
            begin
                wr_q <= wr_d;
                cmt_q <= cmt_d;
                rd_q <= rd_d;
                in_frame_q <= in_frame_d;
                fwd_q <= fwd_d;
                ct_q <= ct_d;
                rdy_q <= rdy_d;
                pend_q <= pend_d;
                val_q <= val_d;
                cnt_q <= cnt_d;
                b0_q <= b0_d;
                b1_q <= b1_d;
                frm_q <= frm_d;
            end
        end

        tpfrs_frame_ram #(
            .WIDTH(EW),
            .AW(AW)
        ) u_ram (
            .clk_i(clk_i),
            .wr_en_i(wr_en),
            .wr_addr_i(wr_q[AW-1:0]),
            .wr_data_i({src_last[d], src_data[d]}),
            .rd_en_i(rd_en),
            .rd_addr_i(rd_q[AW-1:0]),
            .rd_data_o(ram_rd)
        );

        assign src_ready[d] = rdy_q;
        assign dst_head[d] = b0_q;
        assign dst_valid[d] = val_q;
        assign frames[d] = frm_q;
    end

endmodule : tpfrs_relay

/* tb/tpfrs_properties.sv */
// port assertions for the two-port frame relay
// assumes relayed frames are spaced by idle time on each path
`timescale 1ns/1ps
module tpfrs_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic ch0_rx_valid_i,
    input wire logic ch0_rx_last_i,
    input wire logic ch0_rx_ready_o,
    input wire logic [7:0] ch0_tx_data_o,
    input wire logic ch0_tx_valid_o,
    input wire logic ch0_tx_last_o,
    input wire logic ch0_tx_ready_i,
    input wire logic [7:0] ch1_tx_data_o,
    input wire logic ch1_tx_valid_o,
    input wire logic ch1_tx_last_o,
    input wire logic ch1_tx_ready_i
);
    // ------
    // mode shadow and frame start
    // ------
    logic [9:0] mode_q, mode_d;
    logic in0_q, in0_d, go0, wr0;
    assign go0 = ch0_rx_valid_i && ch0_rx_ready_o && !in0_q;
    assign wr0 = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    // writes land at the ack edge, so the shadow follows there
    always_comb
    begin
        mode_d = mode_q;
        in0_d = in0_q;
        if (wr0 && wb_adr_i == tpfrs_pkg::TPFRS_OFS_MODE)
        begin
            if (wb_sel_i[1])
                mode_d[9:8] = wb_dat_i[9:8];
            if (wb_sel_i[0])
                mode_d[0] = wb_dat_i[0];
        end
        if (ch0_rx_valid_i && ch0_rx_ready_o)
            in0_d = !ch0_rx_last_i;
    end
    always_ff @(posedge clk_i)
    begin
        mode_q <= rst_i ? 10'h000 : mode_d;
        in0_q <= !rst_i && in0_d;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // a tx path already busy would hide the start, so demand it idle
    sequence s_cut0;
        go0 && mode_q[8] && mode_q[0] && !ch1_tx_valid_o;
    endsequence
    sequence s_saf0;
        go0 && mode_q[8] && !mode_q[0] && !ch1_tx_valid_o;
    endsequence
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_idle_a: assert property (!wb_stb_i |=> !wb_ack_o)
        else $error("ack without request");
    tx0_hold_a: assert property (ch0_tx_valid_o && !ch0_tx_ready_i |=> ch0_tx_valid_o
        && $stable(ch0_tx_data_o) && $stable(ch0_tx_last_o)) else $error("ch0 byte moved");
    tx1_hold_a: assert property (ch1_tx_valid_o && !ch1_tx_ready_i |=> ch1_tx_valid_o
        && $stable(ch1_tx_data_o) && $stable(ch1_tx_last_o)) else $error("ch1 byte moved");
    cut_delay_a: assert property (s_cut0 |-> ##3 ch1_tx_valid_o)
        else $error("cut-through start late");
    store_wait_a: assert property (s_saf0 |=> !ch1_tx_valid_o [*2])
        else $error("store-and-forward sent early");
    off_quiet_a: assert property (go0 && !mode_q[8] && !ch1_tx_valid_o
        |=> !ch1_tx_valid_o [*8]) else $error("disabled path relayed");
endmodule : tpfrs_properties

bind tpfrs_relay tpfrs_properties props (.*);

/* tb/tpfrs_mac_model.sv */
// mac channel model: sends frames into the relay, sinks relayed bytes
// assumes the bench calls send right after a clock edge
`timescale 1ns/1ps
module tpfrs_mac_model (
    input wire logic clk_i,
    output logic [7:0] data_o = 8'h00,
    output logic valid_o = 1'b0,
    output logic last_o = 1'b0,
    input wire logic ready_i,
    input wire logic [7:0] data_i,
    input wire logic valid_i,
    input wire logic last_i,
    output logic ready_o = 1'b1
);
    logic [7:0] got[$];
    logic stall = 1'b0;
    logic mid = 1'b0;
    int frames = 0;
    int err = 0;
    time t_start, t_first;
    // sink; a stall holds ready low to back up the relay
    always @(posedge clk_i)
    begin
        ready_o <= !stall;
        if (valid_i && ready_o)
        begin
            got.push_back(data_i);
            if (!mid)
                t_first = $time;
            mid = !last_i;
            frames += last_i;
        end
    end
    task automatic send(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++)
        begin
            data_o <= b + 8'(i);
            valid_o <= 1'b1;
            last_o <= (i == n - 1);
            @(posedge clk_i);
            for (int k = 0; k < 99 && !ready_i; k++)
                @(posedge clk_i);
            err += !ready_i;
            if (i == 0)
                t_start = $time;
        end
        valid_o <= 1'b0;
        last_o <= 1'b0;
        data_o <= ~data_o; // released line shows no stale byte
    endtask : send
endmodule : tpfrs_mac_model

/* tb/tpfrs_relay_test.sv */
// bench for the two-port frame relay: bus tasks and one task per test
// assumes the mac model and the bound checker are compiled alongside
`timescale 1ns/1ps
module tpfrs_relay_test;
    localparam logic [31:0] OMODE = tpfrs_pkg::TPFRS_OFS_MODE;
    localparam logic [31:0] OCNT = tpfrs_pkg::TPFRS_OFS_COUNT;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic [3:0] sel = 4'hf;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0, dat = 32'h0, dat_o, rd;
    logic ack, v0r, l0r, r0r, v0t, l0t, r0t, v1r, l1r, r1r, v1t, l1t, r1t;
    logic [7:0] d0r, d0t, d1r, d1t;
    int bad_count = 0;
    int num_checks = 0;
    always #5 clk_i = ~clk_i;
    tpfrs_relay #(.AW(5)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .ch0_rx_data_i(d0r), .ch0_rx_valid_i(v0r),
        .ch0_rx_last_i(l0r), .ch0_rx_ready_o(r0r), .ch0_tx_data_o(d0t), .ch0_tx_valid_o(v0t),
        .ch0_tx_last_o(l0t), .ch0_tx_ready_i(r0t), .ch1_rx_data_i(d1r), .ch1_rx_valid_i(v1r),
        .ch1_rx_last_i(l1r), .ch1_rx_ready_o(r1r), .ch1_tx_data_o(d1t), .ch1_tx_valid_o(v1t),
        .ch1_tx_last_o(l1t), .ch1_tx_ready_i(r1t));
    tpfrs_mac_model mac0 (.clk_i(clk_i), .data_o(d0r), .valid_o(v0r), .last_o(l0r),
        .ready_i(r0r), .data_i(d0t), .valid_i(v0t), .last_i(l0t), .ready_o(r0t));
    tpfrs_mac_model mac1 (.clk_i(clk_i), .data_o(d1r), .valid_o(v1r), .last_o(l1r),
        .ready_i(r1r), .data_i(d1t), .valid_i(v1t), .last_i(l1t), .ready_o(r1t));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    // one classic cycle; request held until the edge that sees ack
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        for (int k = 0; k < 20 && ack !== 1'b1; k++)
            @(posedge clk_i);
        bad_count += (ack !== 1'b1);
        if (ack !== 1'b1)
            give_verdict();
        rd = dat_o;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic t_regs;
        wb(1'b1, OMODE, 32'hffff_ffff);
        wb(1'b0, OMODE, 32'h0);
        chk(rd, 32'h0000_0301);
        // upper lane only: enables clear, method bit must survive
        sel <= 4'h2;
        wb(1'b1, OMODE, 32'h0);
        sel <= 4'hf;
        wb(1'b0, OMODE, 32'h0);
        chk(rd, 32'h0000_0001);
        wb(1'b1, OCNT, 32'hffff_ffff);
        wb(1'b0, OCNT, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 32'h0000_0008, 32'h0);
        chk(rd, 32'h0);
        $display("test regs done");
    endtask : t_regs
    // every enable and method pair, frames sent both ways at once
    task automatic t_modes;
        logic [31:0] m;
        int e0 = 0;
        int e1 = 0;
        for (int i = 0; i < 8; i++)
        begin
            m = {22'h0, 2'(3 - i / 2), 7'h0, 1'(~i)};
            wb(1'b1, OMODE, m);
            fork
                mac0.send(4, 8'h10);
                mac1.send(4, 8'h80);
            join
            repeat (40) @(posedge clk_i);
            e1 += m[8];
            e0 += m[9];
            chk(mac1.frames, e1);
            chk(mac0.frames, e0);
        end
        chk(mac1.got[$], 8'h13);
        chk(mac0.got[$], 8'h83);
        wb(1'b0, OCNT, 32'h0);
        chk(rd, {16'(e0), 16'(e1)});
        $display("test modes done");
    endtask : t_modes
    task automatic t_lat;
        time ct;
        wb(1'b1, OMODE, 32'h0000_0101);
        mac0.send(16, 8'h00);
        repeat (40) @(posedge clk_i);
        ct = mac1.t_first - mac0.t_start;
        chk(32'(ct / 10), 32'h3);
        wb(1'b1, OMODE, 32'h0000_0100);
        mac0.send(16, 8'h00);
        repeat (40) @(posedge clk_i);
        chk(32'(mac1.t_first - mac0.t_start > 150), 32'h1);
        chk(32'(mac1.t_first - mac0.t_start > ct), 32'h1);
        $display("test latency done");
    endtask : t_lat
    // far side stalls until the buffer refuses, then drains it
    task automatic t_buf;
        int base;
        base = mac1.got.size();
        wb(1'b1, OMODE, 32'h0000_0101);
        mac1.stall <= 1'b1;
        fork
            mac0.send(40, 8'h40);
            begin
                repeat (60) @(posedge clk_i);
                mac1.stall <= 1'b0;
            end
        join
        repeat (60) @(posedge clk_i);
        chk(mac1.got.size() - base, 32'd40);
        for (int j = 0; j < 40; j++)
            chk(mac1.got[base + j], 8'h40 + 8'(j));
        // totals so far: seven frames ch0 to ch1, four ch1 to ch0
        wb(1'b0, OCNT, 32'h0);
        chk(rd, 32'h0004_0007);
        $display("test buffer done");
    endtask : t_buf
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_modes();
        t_lat();
        t_buf();
        chk(32'(mac0.err + mac1.err), 32'h0);
        give_verdict();
    end
endmodule : tpfrs_relay_test
